// *** logic/cfd_clock_fanout.v ***
/*
  Clock fanout with source select and per-output divide by two, plus an
  AXI4-Lite slave holding the control bits.
  Assumes the clock pins are sampled as data by sys_clk_in, so a source must
  toggle well below half the system rate to be followed faithfully.
*/
`timescale 1ns/10ps
`include "cfd_regs.vh"

module cfd_clock_fanout (
  // Clock and reset
  input wire sys_clk_in,
  input wire arst_n_in,
  // Clock pins
  input wire single_ended_clock_in_a_in,
  input wire single_ended_clock_in_b_in,
  input wire diff_clock_p_in,
  input wire diff_clock_n_in,
  // Fanout outputs, two signals per pin
  output wire [`CFD_NUM_OUT-1:0] clk_fan_out,
  output wire [`CFD_NUM_OUT-1:0] clk_fan_oe_out,
  // AXI4-Lite write address
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [`CFD_ADDR_W-1:0] s_axi_awaddr_in,
  // AXI4-Lite write data
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  input wire [`CFD_DATA_W-1:0] s_axi_wdata_in,
  input wire [`CFD_STRB_W-1:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output wire [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  input wire [`CFD_ADDR_W-1:0] s_axi_araddr_in,
  // AXI4-Lite read data
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output wire [`CFD_DATA_W-1:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out
);

  // ----------------------------------------------------------------
  // Address decode, shared by read and write
  // ----------------------------------------------------------------
  function [1:0] cfd_decode;
    input [`CFD_ADDR_W-1:0] addr;
    begin
      case (addr)
        `CFD_CTRL_OFS: cfd_decode = `CFD_SEL_CTRL;
        `CFD_DIV_OFS: cfd_decode = `CFD_SEL_DIV;
        `CFD_STAT_OFS: cfd_decode = `CFD_SEL_STAT;
        default: cfd_decode = `CFD_SEL_NONE;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into an old word
  function [`CFD_DATA_W-1:0] cfd_merge;
    input [`CFD_DATA_W-1:0] old_word;
    input [`CFD_DATA_W-1:0] new_word;
    input [`CFD_STRB_W-1:0] strb;
    integer b;
    begin
      cfd_merge = old_word;
      for (b = 0; b < `CFD_STRB_W; b = b + 1) begin
        if (strb[b]) begin
          cfd_merge[b*8 +: 8] = new_word[b*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [`CFD_CTRL_W-1:0] ctrl_reg;
  reg [`CFD_NUM_OUT-1:0] div_reg;
  reg [`CFD_PIN_W-1:0] pin_s1_reg;
  reg [`CFD_PIN_W-1:0] pin_s2_reg;
  reg src_prev_reg;
  reg src_q_reg;
  reg half_reg;
  reg out_en_reg;
  reg [`CFD_NUM_OUT-1:0] fan_reg;
  reg [`CFD_NUM_OUT-1:0] fan_oe_reg;
  reg awready_reg;
  reg wready_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [`CFD_ADDR_W-1:0] awaddr_reg;
  reg [`CFD_DATA_W-1:0] wdata_reg;
  reg [`CFD_STRB_W-1:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg arready_reg;
  reg rvalid_reg;
  reg [`CFD_DATA_W-1:0] rdata_reg;
  reg [1:0] rresp_reg;

  // ----------------------------------------------------------------
  // Pin synchronisers and source selection
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_s1_reg <= `CFD_PIN_RST;
      pin_s2_reg <= `CFD_PIN_RST;
    end else begin
      pin_s1_reg <= {diff_clock_n_in, diff_clock_p_in,
                     single_ended_clock_in_b_in, single_ended_clock_in_a_in};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire float_en = ctrl_reg[`CFD_CTRL_FLOAT_BIT];
  // An idle or common-mode differential pair reads as low
  wire diff_level = pin_s2_reg[`CFD_PIN_DIFF_P] & ~pin_s2_reg[`CFD_PIN_DIFF_N];
  wire se_level = ctrl_reg[`CFD_CTRL_SE_BIT] ? pin_s2_reg[`CFD_PIN_SE_B] :
                  pin_s2_reg[`CFD_PIN_SE_A];
  wire src_level = ctrl_reg[`CFD_CTRL_DIFF_BIT] ? diff_level : se_level;
  wire src_rise = src_level & ~src_prev_reg;

  // ----------------------------------------------------------------
  // Divider and retimed fanout
  // ----------------------------------------------------------------
  // Full and half rate are both registered from the same sampled edge, so
  // every output moves on the same system edge whatever its ratio.
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      src_prev_reg <= 1'b0;
      src_q_reg <= 1'b0;
      half_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
      src_q_reg <= src_level;
      out_en_reg <= ~float_en;
      if (float_en) begin
        half_reg <= 1'b0;
      end else if (src_rise) begin
        half_reg <= ~half_reg;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CFD_NUM_OUT; gi = gi + 1) begin : g_fan
      wire half_next = (float_en | ~src_rise) ? (half_reg & ~float_en) : ~half_reg;
      always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          fan_reg[gi] <= 1'b0;
          fan_oe_reg[gi] <= 1'b0;
        end else if (float_en) begin
          fan_reg[gi] <= 1'b0;
          fan_oe_reg[gi] <= 1'b0;
        end else begin
          fan_reg[gi] <= div_reg[gi] ? half_next : src_level;
          fan_oe_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Sampling bounds the followed rate to well under half of sys_clk_in
  assign clk_fan_out = fan_reg;
  assign clk_fan_oe_out = fan_oe_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  wire [1:0] wsel = cfd_decode(awaddr_reg);
  wire [`CFD_DATA_W-1:0] ctrl_word = {{(`CFD_DATA_W-`CFD_CTRL_W){1'b0}}, ctrl_reg};
  wire [`CFD_DATA_W-1:0] div_word = {{(`CFD_DATA_W-`CFD_NUM_OUT){1'b0}}, div_reg};
  wire [`CFD_DATA_W-1:0] ctrl_merged = cfd_merge(ctrl_word, wdata_reg, wstrb_reg);
  wire [`CFD_DATA_W-1:0] div_merged = cfd_merge(div_word, wdata_reg, wstrb_reg);
  wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_reg <= `CFD_CTRL_RST;
      div_reg <= `CFD_DIV_RST;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= {`CFD_ADDR_W{1'b0}};
      wdata_reg <= `CFD_ZERO32;
      wstrb_reg <= {`CFD_STRB_W{1'b0}};
      bvalid_reg <= 1'b0;
      bresp_reg <= `CFD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && awready_reg) begin
        awaddr_reg <= s_axi_awaddr_in;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid_in && wready_reg) begin
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= `CFD_RESP_OKAY;
        case (wsel)
          `CFD_SEL_CTRL: ctrl_reg <= ctrl_merged[`CFD_CTRL_W-1:0];
          `CFD_SEL_DIV: div_reg <= div_merged[`CFD_NUM_OUT-1:0];
          `CFD_SEL_STAT: bresp_reg <= `CFD_RESP_OKAY;
          default: bresp_reg <= `CFD_RESP_SLVERR;
        endcase
      end
      if (bvalid_reg && s_axi_bready_in) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  reg [`CFD_DATA_W-1:0] rd_word;
  always @* begin
    rd_word = `CFD_ZERO32;
    case (cfd_decode(s_axi_araddr_in))
      `CFD_SEL_CTRL: rd_word = ctrl_word;
      `CFD_SEL_DIV: rd_word = div_word;
      `CFD_SEL_STAT: begin
        rd_word[`CFD_STAT_SRC_BIT] = src_q_reg;
        rd_word[`CFD_STAT_HALF_BIT] = half_reg;
        rd_word[`CFD_STAT_OE_BIT] = out_en_reg;
      end
      default: rd_word = `CFD_ZERO32;
    endcase
  end

  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= `CFD_ZERO32;
      rresp_reg <= `CFD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        if (cfd_decode(s_axi_araddr_in) == `CFD_SEL_NONE) begin
          rresp_reg <= `CFD_RESP_SLVERR;
        end else begin
          rresp_reg <= `CFD_RESP_OKAY;
        end
      end else if (rvalid_reg && s_axi_rready_in) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;

endmodule // cfd_clock_fanout

// *** logic/cfd_regs.vh ***
/*
  Constants for the clock fanout and divide-select block: register offsets,
  field positions, reset values and bus codes.
  Assumes inclusion by bare name from the design file under logic/.
*/
`ifndef CFD_REGS_VH
`define CFD_REGS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define CFD_NUM_OUT 15
`define CFD_ADDR_W 4
`define CFD_DATA_W 32
`define CFD_STRB_W 4

// ----------------------------------------------------------------
// Clock pin sampling
// ----------------------------------------------------------------
`define CFD_PIN_W 4
`define CFD_PIN_RST 4'h0
`define CFD_PIN_SE_A 0
`define CFD_PIN_SE_B 1
`define CFD_PIN_DIFF_P 2
`define CFD_PIN_DIFF_N 3

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CFD_CTRL_OFS 4'h0
`define CFD_DIV_OFS 4'h4
`define CFD_STAT_OFS 4'h8

// ----------------------------------------------------------------
// Decoder select codes
// ----------------------------------------------------------------
`define CFD_SEL_NONE 2'h0
`define CFD_SEL_CTRL 2'h1
`define CFD_SEL_DIV 2'h2
`define CFD_SEL_STAT 2'h3

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CFD_CTRL_SE_BIT 0
`define CFD_CTRL_DIFF_BIT 1
`define CFD_CTRL_FLOAT_BIT 2
`define CFD_CTRL_W 3
`define CFD_CTRL_RST 3'h0
`define CFD_DIV_RST 15'h0000

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define CFD_STAT_SRC_BIT 0
`define CFD_STAT_HALF_BIT 1
`define CFD_STAT_OE_BIT 2

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define CFD_RESP_OKAY 2'h0
`define CFD_RESP_SLVERR 2'h2
`define CFD_ZERO32 32'h0000_0000

`endif

// *** dv/cfd_clock_source.sv ***
/* Clock source model for the fanout block's four clock pins.
   Assumes the pins are sampled by a 100 MHz system clock. */
`timescale 1ns/10ps
module cfd_clock_source (
  // Clock pins
  output logic src_a_out,
  output logic src_b_out,
  output logic diff_p_out,
  output logic diff_n_out
);
  // ----
  // Sources
  // ----
  // Unequal periods so a wrong choice shows; edges avoid system edges
  initial begin
    src_a_out = 1'h0;
    src_b_out = 1'h0;
    diff_p_out = 1'h0;
    #2;
    fork
      forever #40 src_a_out = ~src_a_out;
      forever #60 src_b_out = ~src_b_out;
      forever #100 diff_p_out = ~diff_p_out;
    join
  end
  assign diff_n_out = ~diff_p_out;
endmodule // cfd_clock_source

// *** dv/cfd_fanout_monitor.sv ***
/* Checker on the fanout block's top ports.
   Assumes one clock domain and the active-low async reset. */
`timescale 1ns/10ps
`include "cfd_regs.vh"
module cfd_fanout_monitor (
  // Clock, reset, pins
  input wire sys_clk_in,
  input wire arst_n_in,
  input wire single_ended_clock_in_a_in,
  input wire single_ended_clock_in_b_in,
  input wire diff_clock_p_in,
  input wire diff_clock_n_in,
  // Fanout
  input wire [`CFD_NUM_OUT-1:0] clk_fan_out,
  input wire [`CFD_NUM_OUT-1:0] clk_fan_oe_out,
  // Bus
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [`CFD_DATA_W-1:0] s_axi_rdata_out
);
  // ----
  // Pin history
  // ----
  logic [3:0] s1, s2, s3, s4;
  logic [3:0] bv;
  always @(posedge sys_clk_in) begin
    s1 <= {single_ended_clock_in_a_in, single_ended_clock_in_b_in,
           diff_clock_p_in, diff_clock_n_in};
    s2 <= s1;
    s3 <= s2;
    s4 <= s3;
    bv <= {bv[2:0], s_axi_bvalid_out};
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----
  // Properties
  // ----
  property p_float_zero;
    !clk_fan_oe_out[0] |-> clk_fan_out == '0;
  endproperty
  a_float_zero: assert property (p_float_zero) else $error("floated output driven");
  property p_oe_same;
    clk_fan_oe_out == '0 || clk_fan_oe_out == '1;
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("enables differ");
  // Bus writes may switch source or divide, so changes near them are excused
  property p_out_cause;
    $changed(clk_fan_out) && clk_fan_oe_out[0] && $stable(clk_fan_oe_out)
      && $past(clk_fan_oe_out[0], 2) && !(s_axi_bvalid_out || |bv) |-> s3 != s4;
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved without source");
  property p_b_soon;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |-> ##[1:2] s_axi_bvalid_out;
  endproperty
  a_b_soon: assert property (p_b_soon) else $error("write response late");
  property p_b_hold;
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_w_block;
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken during response");
  property p_r_soon;
    s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out;
  endproperty
  a_r_soon: assert property (p_r_soon) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block;
    s_axi_rvalid_out |-> !s_axi_arready_out;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during data");
  cover property ($fell(clk_fan_oe_out[0]));
  cover property (s_axi_bvalid_out && s_axi_bready_in);
  cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule // cfd_fanout_monitor
bind cfd_clock_fanout cfd_fanout_monitor i_cfd_fanout_monitor (.sys_clk_in, .arst_n_in,
  .single_ended_clock_in_a_in, .single_ended_clock_in_b_in, .diff_clock_p_in,
  .diff_clock_n_in, .clk_fan_out, .clk_fan_oe_out, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .s_axi_rready_in,
  .s_axi_rdata_out);

// *** dv/tb.sv ***
/* Bench for the clock fanout block: register, float and fanout tests.
   Assumes the design, its header and the source model are compiled. */
`timescale 1ns/10ps
`include "cfd_regs.vh"
module tb;
  // ----
  // Signals
  // ----
  logic sys_clk_in, arst_n_in, se, df;
  logic single_ended_clock_in_a_in, single_ended_clock_in_b_in, diff_clock_p_in, diff_clock_n_in;
  logic [`CFD_NUM_OUT-1:0] clk_fan_out, clk_fan_oe_out;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic s_axi_rvalid_out, s_axi_rready_in;
  logic [3:0] s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [11:0] h;
  logic [14:0] masks [3] = '{15'h0000, 15'h7FFF, 15'h4A53};
  int fails, cmp_count, cycles;
  cfd_clock_fanout i_cfd_clock_fanout (.sys_clk_in, .arst_n_in, .single_ended_clock_in_a_in,
    .single_ended_clock_in_b_in, .diff_clock_p_in, .diff_clock_n_in, .clk_fan_out,
    .clk_fan_oe_out, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_awaddr_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_bresp_out, .s_axi_arvalid_in,
    .s_axi_arready_out, .s_axi_araddr_in, .s_axi_rvalid_out, .s_axi_rready_in,
    .s_axi_rdata_out, .s_axi_rresp_out);
  cfd_clock_source i_cfd_clock_source (.src_a_out(single_ended_clock_in_a_in),
    .src_b_out(single_ended_clock_in_b_in), .diff_p_out(diff_clock_p_in),
    .diff_n_out(diff_clock_n_in));
  initial begin
    sys_clk_in = 1'h0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // Pins as the design's two sampling flops see them, plus a hang limit
  always @(posedge sys_clk_in) begin
    h <= {h[8:0], single_ended_clock_in_a_in, single_ended_clock_in_b_in,
          diff_clock_p_in & ~diff_clock_n_in};
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      report_and_stop;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic check(input string nm, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_wstrb_in <= st;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
    end while (!s_axi_bvalid_out);
    s_axi_bready_in <= 1'h0;
    check("bresp", {30'h0, er}, {30'h0, s_axi_bresp_out});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] msk, exp, input logic [1:0] er);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
    end while (!s_axi_rvalid_out);
    s_axi_rready_in <= 1'h0;
    check("rdata", exp, s_axi_rdata_out & msk);
    check("rresp", {30'h0, er}, {30'h0, s_axi_rresp_out});
  endtask
  // Half rate starts low at float release and toggles on each source rise
  task automatic follow(input logic [14:0] m);
    int i;
    logic f, pf, hx;
    i = 0;
    while (clk_fan_oe_out !== 15'h7FFF && i < 20) begin
      @(negedge sys_clk_in);
      i++;
    end
    // Oldest sample is the source level one edge before the first enabled edge
    pf = df ? h[9] : (se ? h[10] : h[11]);
    hx = 1'b0;
    for (i = 0; i < 60; i++) begin
      f = df ? h[6] : (se ? h[7] : h[8]);
      if (f && !pf) hx = !hx;
      pf = f;
      check("fan", {17'h0, (m & {15{hx}}) | (~m & {15{f}})}, {17'h0, clk_fan_out});
      check("oe", 32'h0000_7FFF, {17'h0, clk_fan_oe_out});
      @(negedge sys_clk_in);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    arst_n_in = 1'h0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in} = 13'h0000;
    s_axi_wdata_in = 32'h0000_0000;
    repeat (16) @(posedge sys_clk_in);
    arst_n_in <= 1'h1;
    rd(`CFD_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0000, `CFD_RESP_OKAY);
    rd(`CFD_DIV_OFS, 32'hFFFF_FFFF, 32'h0000_0000, `CFD_RESP_OKAY);
    rd(4'hC, 32'hFFFF_FFFF, 32'h0000_0000, `CFD_RESP_SLVERR);
    wr(4'hC, 32'hFFFF_FFFF, 4'hF, `CFD_RESP_SLVERR);
    wr(`CFD_STAT_OFS, 32'hFFFF_FFFF, 4'hF, `CFD_RESP_OKAY);
    rd(`CFD_STAT_OFS, 32'hFFFF_FFFC, 32'h0000_0004, `CFD_RESP_OKAY);
    wr(`CFD_DIV_OFS, 32'hFFFF_FFFF, 4'h2, `CFD_RESP_OKAY);
    rd(`CFD_DIV_OFS, 32'hFFFF_FFFF, 32'h0000_7F00, `CFD_RESP_OKAY);
    $display("test registers done");
    wr(`CFD_CTRL_OFS, 32'hFFFF_FFFF, 4'hF, `CFD_RESP_OKAY);
    rd(`CFD_CTRL_OFS, 32'hFFFF_FFFF, 32'h0000_0007, `CFD_RESP_OKAY);
    @(negedge sys_clk_in);
    check("float", 32'h0000_0000, {2'h0, clk_fan_out, clk_fan_oe_out});
    rd(`CFD_STAT_OFS, 32'hFFFF_FFFE, 32'h0000_0000, `CFD_RESP_OKAY);
    $display("test float done");
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 4; k++) begin
        se = k[0];
        df = k[1];
        wr(`CFD_DIV_OFS, {17'h0, masks[m]}, 4'hF, `CFD_RESP_OKAY);
        wr(`CFD_CTRL_OFS, {29'h0, 1'h1, df, se}, 4'hF, `CFD_RESP_OKAY);
        wr(`CFD_CTRL_OFS, {29'h0, 1'h0, df, se}, 4'hF, `CFD_RESP_OKAY);
        follow(masks[m]);
      end
    end
    $display("test fanout done");
    report_and_stop;
  end
endmodule // tb
